// File: include/timer_pkg.sv
package timer_pkg;
    // register byte addresses
    localparam logic [7:0] CTRL_ADDR     = 8'h0a;
    localparam logic [7:0] FLAGS_ADDR    = 8'h0b;
    localparam logic [7:0] CAP_HIGH_ADDR = 8'h0c;
    localparam logic [7:0] CAP_LOW_ADDR  = 8'h0d;
    localparam logic [7:0] CMP_HIGH_ADDR = 8'h0e;
    localparam logic [7:0] CMP_LOW_ADDR  = 8'h0f;
    localparam logic [7:0] CNT_HIGH_ADDR = 8'h10;
    localparam logic [7:0] CNT_LOW_ADDR  = 8'h11;
    localparam logic [7:0] ALT_HIGH_ADDR = 8'h12;
    localparam logic [7:0] ALT_LOW_ADDR  = 8'h13;
    // control register fields
    localparam int CAP_IE_BIT   = 7;
    localparam int CMP_IE_BIT   = 6;
    localparam int OVF_IE_BIT   = 5;
    localparam int CMP_PIN_BIT  = 4;
    localparam int CAP_PIN_BIT  = 3;
    localparam int EDGE_BIT     = 1;
    localparam int OUT_LVL_BIT  = 0;
    // flag vector positions, also status bits 7..5
    localparam int CAP_FLAG     = 2;
    localparam int CMP_FLAG     = 1;
    localparam int OVF_FLAG     = 0;
    localparam int FLAG_COUNT   = 3;
    // pin positions on the shared port
    localparam int CMP_PIN      = 0;
    localparam int CAP_PIN      = 1;
    // reset values and counts
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [15:0] CNT_RESET    = 16'hfffc;
    localparam logic [15:0] CNT_TOP      = 16'hffff;
    localparam logic [1:0]  PRESCALE_LAST = 2'h3;
endpackage

// File: include/timer_core_if.sv
`timescale 1ns/1ps
interface timer_core_if;
    logic [15:0] cnt;
    logic        step;
    logic        wrap;
    logic        stop;
    logic        cap_pin;
    logic        edge_sel;
    logic        cap_block;
    logic        cap_load;
    logic        cap_flag_set;
    logic [15:0] cap_value;

    modport counter (output cnt, step, wrap, input stop);
    modport capture (input cnt, stop, cap_pin, edge_sel, cap_block,
                     output cap_load, cap_flag_set, cap_value);
    modport core (input cnt, step, wrap, cap_load, cap_flag_set,
                  cap_value, output stop, cap_pin, edge_sel, cap_block);
endinterface

// File: hdl/prescale_counter.sv
`timescale 1ns/1ps
module prescale_counter
(
    // clock and reset
    input  wire logic   mclk_i,
    input  wire logic   rst_i,
    // counter side
    timer_core_if.counter tc
);
    logic [1:0] presc;

    // stop freezes the prescaler too, so the count resumes in phase
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            presc <= 2'h0;
        else if (!tc.stop)
            presc <= presc + 2'h1;
    end

    assign tc.step = !tc.stop && (presc == timer_pkg::PRESCALE_LAST);
    assign tc.wrap = tc.step && (tc.cnt == timer_pkg::CNT_TOP);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tc.cnt <= timer_pkg::CNT_RESET;
        else if (tc.step)
            tc.cnt <= tc.cnt + 16'h0001;
    end
endmodule

// File: hdl/capture_unit.sv
`timescale 1ns/1ps
module capture_unit
(
    // clock and reset
    input  wire logic   mclk_i,
    input  wire logic   rst_i,
    // capture side
    timer_core_if.capture tc
);
    logic        pin_q;
    logic        seen_q;
    logic        stop_q;
    logic        armed_q;
    logic [15:0] pend_q;
    logic        hit;
    logic        wake;

    // seen_q hides the false edge right after reset
    assign hit  = seen_q && (tc.edge_sel ? (tc.cap_pin && !pin_q)
                                         : (!tc.cap_pin && pin_q));
    assign wake = stop_q && !tc.stop;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pin_q  <= 1'b0;
            seen_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            pin_q  <= tc.cap_pin;
            seen_q <= 1'b1;
            stop_q <= tc.stop;
        end
    end

    // first edge in stop is held until wake; reset during stop drops it, but a reset that ends stop still loads pend_q
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            armed_q <= 1'b0;
        else if (tc.stop && hit && !armed_q)
            armed_q <= 1'b1;
        else if (wake)
            armed_q <= 1'b0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (tc.stop && hit && !armed_q)
            pend_q <= tc.cnt + 16'h0001;
    end

    assign tc.cap_flag_set = (hit && !tc.stop) || (wake && armed_q);
    assign tc.cap_load     = tc.cap_flag_set && !tc.cap_block;

    // no reset: the captured value survives it
    always_ff @(posedge mclk_i)
    begin
        if (tc.cap_load)
            tc.cap_value <= wake ? pend_q : tc.cnt + 16'h0001;
    end
endmodule

// File: hdl/timer_capture_control_status.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - 16-bit free-running counter steps once every four bus clocks.
// - selected edge on capture input copies counter into capture register.
// - reset leaves capture register alone; it holds the latest capture.
// - captured value is counter before the transition plus one.
// - capture transfer happens whether or not capture flag is set.
// - reading capture high byte blocks transfers until low byte read.
// - reading capture low byte alone never blocks a transfer.
// - control holds three irq enables in bits 7..5; bit 2 reads 0.
// - compare pin mode drives port bit 0 with the pin register level.
// - capture pin mode frees port bit 1; gpio edges still capture.
// - edge select 1 rising, 0 falling; reset does not touch it.
// - compare match loads output level bit into the pin register.
// - status holds capture, compare, overflow flags; bits 4..0 read 0.
// - flag clears by status access while set, then its low register.
// - alternate counter reads match counter and never clear overflow.
// - counter keeps running in wait; enabled irq wakes processor.
// - stop halts counter; reset forces preset value.
// - edge in stop arms capture; flag and data appear on wake.
// - reset ending stop discards the armed capture's flag; its data still reaches the capture register.
module timer_capture_control_status
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // power mode
    input  wire logic       stop_mode_i,
    // shared port pins
    input  wire logic [1:0] pb_i,
    input  wire logic [1:0] port_dout_i,
    input  wire logic [1:0] port_ddr_i,
    output logic      [1:0] pb_o,
    output logic      [1:0] pb_oe_o,
    // interrupt
    output logic            timer_irq_o
);
    timer_core_if tc ();
    localparam int FLAG_COUNT = timer_pkg::FLAG_COUNT;
    logic                  capture_irq_enable;
    logic                  compare_irq_enable;
    logic                  overflow_irq_enable;
    logic                  compare_pin_select;
    logic                  capture_pin_select;
    logic                  capture_edge_select;
    logic                  compare_output_level;
    logic [FLAG_COUNT-1:0] flags;
    logic [FLAG_COUNT-1:0] arm;
    logic [FLAG_COUNT-1:0] flag_set;
    logic [FLAG_COUNT-1:0] low_acc;
    logic                  status_acc;
    logic                  cap_block_q;
    logic                  cmp_block;
    logic                  cmp_match;
    logic                  compare_output_level_q;
    logic [7:0]            cmp_high;
    logic [7:0]            cmp_low;
    logic [7:0]            cnt_buf;
    logic                  cnt_buf_valid;
    logic [7:0]            next_rdata;

    // byte address decode shared by the write and strobe logic; the read mux decodes addr_i in its own case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    prescale_counter u_counter
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tc     (tc.counter)
    );

    capture_unit u_capture
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tc     (tc.capture)
    );

    // wait mode is not an input: the counter has no reason to stop
    assign tc.stop     = stop_mode_i;
    // pin level feeds the detector in both pin modes
    assign tc.cap_pin  = pb_i[timer_pkg::CAP_PIN];
    assign tc.edge_sel = capture_edge_select;
    // the low read ends the block in the same cycle
    assign tc.cap_block = cap_block_q
                        && !(rd_i && hit(addr_i, timer_pkg::CAP_LOW_ADDR));

    // control register; edge select keeps its value over reset
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            capture_irq_enable   <= timer_pkg::CTRL_RESET[7];
            compare_irq_enable   <= timer_pkg::CTRL_RESET[6];
            overflow_irq_enable  <= timer_pkg::CTRL_RESET[5];
            compare_pin_select   <= timer_pkg::CTRL_RESET[4];
            capture_pin_select   <= timer_pkg::CTRL_RESET[3];
            compare_output_level <= timer_pkg::CTRL_RESET[0];
        end
        else if (wr_i && hit(addr_i, timer_pkg::CTRL_ADDR))
        begin
            capture_irq_enable   <= wdata_i[timer_pkg::CAP_IE_BIT];
            compare_irq_enable   <= wdata_i[timer_pkg::CMP_IE_BIT];
            overflow_irq_enable  <= wdata_i[timer_pkg::OVF_IE_BIT];
            compare_pin_select   <= wdata_i[timer_pkg::CMP_PIN_BIT];
            capture_pin_select   <= wdata_i[timer_pkg::CAP_PIN_BIT];
            compare_output_level <= wdata_i[timer_pkg::OUT_LVL_BIT];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (wr_i && hit(addr_i, timer_pkg::CTRL_ADDR))
            capture_edge_select <= wdata_i[timer_pkg::EDGE_BIT];
    end

    // capture block after a high-byte read
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cap_block_q <= 1'b0;
        else if (rd_i && hit(addr_i, timer_pkg::CAP_HIGH_ADDR))
            cap_block_q <= 1'b1;
        else if (rd_i && hit(addr_i, timer_pkg::CAP_LOW_ADDR))
            cap_block_q <= 1'b0;
    end

    // compare register: not reset, high write holds off matches
    always_ff @(posedge mclk_i)
    begin
        if (wr_i && hit(addr_i, timer_pkg::CMP_HIGH_ADDR))
            cmp_high <= wdata_i;
        if (wr_i && hit(addr_i, timer_pkg::CMP_LOW_ADDR))
            cmp_low <= wdata_i;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cmp_block <= 1'b0;
        else if (wr_i && hit(addr_i, timer_pkg::CMP_HIGH_ADDR))
            cmp_block <= 1'b1;
        else if (wr_i && hit(addr_i, timer_pkg::CMP_LOW_ADDR))
            cmp_block <= 1'b0;
    end

    // match judged on the value the counter steps to
    assign cmp_match = tc.step && !cmp_block
                     && (tc.cnt + 16'h0001 == {cmp_high, cmp_low});

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            compare_output_level_q <= 1'b0;
        else if (cmp_match)
            compare_output_level_q <= compare_output_level;
    end

    // low byte frozen by the first high read of either counter pair
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cnt_buf_valid <= 1'b0;
        else if (rd_i && (hit(addr_i, timer_pkg::CNT_HIGH_ADDR)
                       || hit(addr_i, timer_pkg::ALT_HIGH_ADDR)))
            cnt_buf_valid <= 1'b1;
        else if (rd_i && (hit(addr_i, timer_pkg::CNT_LOW_ADDR)
                       || hit(addr_i, timer_pkg::ALT_LOW_ADDR)))
            cnt_buf_valid <= 1'b0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rd_i && !cnt_buf_valid
            && (hit(addr_i, timer_pkg::CNT_HIGH_ADDR)
             || hit(addr_i, timer_pkg::ALT_HIGH_ADDR)))
            cnt_buf <= tc.cnt[7:0];
    end

    // flags: an access to status arms, the low register clears
    assign status_acc = (rd_i || wr_i) && hit(addr_i, timer_pkg::FLAGS_ADDR);
    assign flag_set[timer_pkg::CAP_FLAG] = tc.cap_flag_set;
    assign flag_set[timer_pkg::CMP_FLAG] = cmp_match;
    assign flag_set[timer_pkg::OVF_FLAG] = tc.wrap;
    // alternate counter addresses are not in this list
    assign low_acc[timer_pkg::CAP_FLAG] = (rd_i || wr_i)
                                    && hit(addr_i, timer_pkg::CAP_LOW_ADDR);
    assign low_acc[timer_pkg::CMP_FLAG] = (rd_i || wr_i)
                                    && hit(addr_i, timer_pkg::CMP_LOW_ADDR);
    assign low_acc[timer_pkg::OVF_FLAG] = (rd_i || wr_i)
                                    && hit(addr_i, timer_pkg::CNT_LOW_ADDR);

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++)
        begin : g_flag
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                    arm[gi] <= 1'b0;
                else if (status_acc && flags[gi])
                    arm[gi] <= 1'b1;
                else if (low_acc[gi])
                    arm[gi] <= 1'b0;
            end

            // set wins over a clear in the same cycle
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                    flags[gi] <= 1'b0;
                else if (flag_set[gi])
                    flags[gi] <= 1'b1;
                else if (arm[gi] && low_acc[gi])
                    flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // read mux, answered one cycle after the strobe
    always_comb
    begin
        next_rdata = 8'h00;
        case (addr_i)
            timer_pkg::CTRL_ADDR:
                next_rdata = {capture_irq_enable, compare_irq_enable,
                              overflow_irq_enable, compare_pin_select,
                              capture_pin_select, 1'b0,
                              capture_edge_select, compare_output_level};
            timer_pkg::FLAGS_ADDR:
                next_rdata = {flags, 5'h00};
            timer_pkg::CAP_HIGH_ADDR:
                next_rdata = tc.cap_value[15:8];
            timer_pkg::CAP_LOW_ADDR:
                next_rdata = tc.cap_value[7:0];
            timer_pkg::CMP_HIGH_ADDR:
                next_rdata = cmp_high;
            timer_pkg::CMP_LOW_ADDR:
                next_rdata = cmp_low;
            timer_pkg::CNT_HIGH_ADDR,
            timer_pkg::ALT_HIGH_ADDR:
                next_rdata = tc.cnt[15:8];
            timer_pkg::CNT_LOW_ADDR,
            timer_pkg::ALT_LOW_ADDR:
                next_rdata = cnt_buf_valid ? cnt_buf : tc.cnt[7:0];
            default:
                next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= next_rdata;
        else
            rdata_o <= 8'h00;
    end

    // pins: mode bits override the direction bits
    assign pb_o[0]    = compare_pin_select ? compare_output_level_q : port_dout_i[0];
    assign pb_oe_o[0] = compare_pin_select || port_ddr_i[0];
    assign pb_o[1]    = port_dout_i[1];
    assign pb_oe_o[1] = !capture_pin_select && port_ddr_i[1];

    // level request; it also ends wait in the processor
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            timer_irq_o <= 1'b0;
        else
            timer_irq_o <= (next_flags_irq());
    end

    function automatic logic next_flags_irq();
        return (flags[timer_pkg::CAP_FLAG] && capture_irq_enable)
            || (flags[timer_pkg::CMP_FLAG] && compare_irq_enable)
            || (flags[timer_pkg::OVF_FLAG] && overflow_irq_enable);
    endfunction

    property p_step_four;
        @(posedge mclk_i) disable iff (rst_i)
        tc.step |=> !tc.step [*3] ##1 (tc.step || tc.stop);
    endproperty
    a_step_four: assert property (p_step_four)
        else $error("counter step spacing is not four clocks");

    property p_cap_plus1;
        @(posedge mclk_i) disable iff (rst_i)
        (tc.cap_load && !tc.stop && !$past(tc.stop))
            |=> tc.cap_value == $past(tc.cnt) + 16'h0001;
    endproperty
    a_cap_plus1: assert property (p_cap_plus1)
        else $error("captured value is not counter plus one");

    property p_cap_block;
        @(posedge mclk_i) disable iff (rst_i)
        tc.cap_block |=> $stable(tc.cap_value);
    endproperty
    a_cap_block: assert property (p_cap_block)
        else $error("capture register changed while blocked");

    property p_ctrl_bit2;
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == timer_pkg::CTRL_ADDR) |=> !rdata_o[2];
    endproperty
    a_ctrl_bit2: assert property (p_ctrl_bit2)
        else $error("control bit 2 read as one");

    property p_status_low;
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == timer_pkg::FLAGS_ADDR)
            |=> rdata_o == {$past(flags), 5'h00};
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("status read does not show the flags");

    property p_ovf_set;
        @(posedge mclk_i) disable iff (rst_i)
        tc.wrap |=> flags[timer_pkg::OVF_FLAG] && tc.cnt == 16'h0000;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("wrap did not set the overflow flag");

    property p_compare_output_level;
        @(posedge mclk_i) disable iff (rst_i)
        cmp_match |=> compare_output_level_q == $past(compare_output_level)
                      && flags[timer_pkg::CMP_FLAG];
    endproperty
    a_compare_output_level: assert property (p_compare_output_level)
        else $error("compare match did not load the level");

    property p_cmp_pin;
        @(posedge mclk_i) disable iff (rst_i)
        compare_pin_select |-> pb_oe_o[0] && pb_o[0] == compare_output_level_q;
    endproperty
    a_cmp_pin: assert property (p_cmp_pin)
        else $error("compare pin not driven with the level");

    property p_cap_pin;
        @(posedge mclk_i) disable iff (rst_i)
        capture_pin_select |-> !pb_oe_o[1];
    endproperty
    a_cap_pin: assert property (p_cap_pin)
        else $error("capture pin driven in capture mode");

    property p_clear;
        @(posedge mclk_i) disable iff (rst_i)
        (arm[timer_pkg::CMP_FLAG] && low_acc[timer_pkg::CMP_FLAG]
            && !cmp_match) |=> !flags[timer_pkg::CMP_FLAG];
    endproperty
    a_clear: assert property (p_clear)
        else $error("armed compare flag not cleared");

    property p_alt_keep;
        @(posedge mclk_i) disable iff (rst_i)
        (flags[timer_pkg::OVF_FLAG] && rd_i
            && addr_i == timer_pkg::ALT_LOW_ADDR)
            |=> flags[timer_pkg::OVF_FLAG];
    endproperty
    a_alt_keep: assert property (p_alt_keep)
        else $error("alternate read cleared overflow");

    property p_stop_halt;
        @(posedge mclk_i) disable iff (rst_i)
        (stop_mode_i && $past(stop_mode_i)) |-> $stable(tc.cnt);
    endproperty
    a_stop_halt: assert property (p_stop_halt)
        else $error("counter moved during stop");

    property p_stop_noflag;
        @(posedge mclk_i) disable iff (rst_i)
        (stop_mode_i && !flags[timer_pkg::CAP_FLAG])
            |=> !flags[timer_pkg::CAP_FLAG] || !$past(stop_mode_i);
    endproperty
    a_stop_noflag: assert property (p_stop_noflag)
        else $error("capture flag set during stop");

    property p_irq;
        @(posedge mclk_i) disable iff (rst_i)
        (flags[timer_pkg::OVF_FLAG] && overflow_irq_enable)
            |=> timer_irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled overflow gave no interrupt");

    c_capture: cover property (@(posedge mclk_i) tc.cap_load);
    c_blocked: cover property (@(posedge mclk_i)
        tc.cap_flag_set && tc.cap_block);
    c_match: cover property (@(posedge mclk_i) cmp_match);
    c_wake: cover property (@(posedge mclk_i)
        $fell(stop_mode_i) ##1 flags[timer_pkg::CAP_FLAG]);
endmodule

// File: tb/pin_partner.sv
`timescale 1ns/1ps
module pin_partner
(
    // capture source from the bench
    input  wire logic       cap_level_i,
    // port pins from the timer
    input  wire logic [1:0] pb_o_i,
    input  wire logic [1:0] pb_oe_i,
    // resolved pin levels
    output logic      [1:0] pb_pin_o
);
    // undriven compare pin rests high through a pull-up
    assign pb_pin_o[0] = pb_oe_i[0] ? pb_o_i[0] : 1'b1;
    // port drive wins over the external source
    assign pb_pin_o[1] = pb_oe_i[1] ? pb_o_i[1] : cap_level_i;
endmodule

// File: tb/timer_capture_control_status_test.sv
`timescale 1ns/1ps
module timer_capture_control_status_test;
    logic        mclk_i      = 1'b0;
    logic        rst_i       = 1'b1;
    logic [7:0]  addr_i      = 8'h00;
    logic [7:0]  wdata_i     = 8'h00;
    logic        wr_i        = 1'b0;
    logic        rd_i        = 1'b0;
    logic        stop_mode_i = 1'b0;
    logic        cap_level   = 1'b0;
    logic [1:0]  port_dout_i = 2'h0;
    logic [1:0]  port_ddr_i  = 2'h0;
    logic [1:0]  pb_i;
    logic [1:0]  pb_o;
    logic [1:0]  pb_oe_o;
    logic [7:0]  rdata_o;
    logic        timer_irq_o;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [15:0] v;
    int          err_count   = 0;
    int          check_count = 0;

    always #12.5 mclk_i = ~mclk_i;

    timer_capture_control_status uut
    (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .stop_mode_i(stop_mode_i), .pb_i(pb_i), .port_dout_i(port_dout_i),
        .port_ddr_i(port_ddr_i), .pb_o(pb_o), .pb_oe_o(pb_oe_o),
        .timer_irq_o(timer_irq_o)
    );

    pin_partner partner
    (
        .cap_level_i(cap_level), .pb_o_i(pb_o), .pb_oe_i(pb_oe_o),
        .pb_pin_o(pb_i)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        @(posedge mclk_i);
        d = rdata_o;
    endtask

    // freeze the counter, note it, then give one rising capture edge
    task automatic capture_in_stop;
        stop_mode_i <= 1'b1;
        idle(4);
        rd(timer_pkg::ALT_HIGH_ADDR, hi);
        rd(timer_pkg::ALT_LOW_ADDR, lo);
        v = {hi, lo} + 16'h0001;
        cap_level <= 1'b1;
        idle(3);
        cap_level <= 1'b0;
        idle(2);
    endtask

    task automatic test_reset;
        // compare loaded early: its reset value is undefined
        wr(timer_pkg::CMP_HIGH_ADDR, 8'h80);
        wr(timer_pkg::CMP_LOW_ADDR, 8'h00);
        // edge armed in stop, then a reset ends stop
        wr(timer_pkg::CTRL_ADDR, 8'h02);
        stop_mode_i <= 1'b1;
        cap_level   <= 1'b1;
        idle(3);
        rst_i       <= 1'b1;
        stop_mode_i <= 1'b0;
        cap_level   <= 1'b0;
        idle(2);
        rst_i       <= 1'b0;
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h00, "flags reset");
        rd(timer_pkg::CTRL_ADDR, lo);
        check(lo, 8'h02, "ctrl reset");
        rd(8'h20, lo);
        check(lo, 8'h00, "unmapped");
        rd(timer_pkg::ALT_HIGH_ADDR, hi);
        check(hi, 8'hff, "counter preset");
        $display("test_reset done");
    endtask

    task automatic test_overflow;
        idle(30);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h20, "overflow set");
        check({7'h00, timer_irq_o}, 8'h00, "irq masked");
        rd(timer_pkg::ALT_LOW_ADDR, lo);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h20, "alt read kept flag");
        rd(timer_pkg::CNT_LOW_ADDR, lo);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h00, "overflow cleared");
        check({7'h00, timer_irq_o}, 8'h00, "irq idle");
        $display("test_overflow done");
    endtask

    task automatic test_ctrl;
        port_ddr_i <= 2'b11;
        wr(timer_pkg::CTRL_ADDR, 8'hff);
        rd(timer_pkg::CTRL_ADDR, lo);
        check(lo, 8'hfb, "ctrl bit 2");
        check({6'h00, pb_oe_o}, 8'h01, "pin modes on");
        wr(timer_pkg::CTRL_ADDR, 8'h00);
        idle(1);
        check({6'h00, pb_oe_o}, 8'h03, "pin modes off");
        port_ddr_i <= 2'b00;
        $display("test_ctrl done");
    endtask

    task automatic test_stop;
        wr(timer_pkg::CTRL_ADDR, 8'h8a);
        capture_in_stop();
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h00, "no flag in stop");
        check({7'h00, timer_irq_o}, 8'h00, "no wake in stop");
        stop_mode_i <= 1'b0;
        idle(3);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h80, "flag on wake");
        check({7'h00, timer_irq_o}, 8'h01, "irq on flag");
        rd(timer_pkg::CAP_HIGH_ADDR, hi);
        rd(timer_pkg::CAP_LOW_ADDR, lo);
        check(hi, v[15:8], "cap high");
        check(lo, v[7:0], "cap low");
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h00, "cap flag cleared");
        idle(2);
        check({7'h00, timer_irq_o}, 8'h00, "irq dropped");
        $display("test_stop done");
    endtask

    task automatic test_block;
        rd(timer_pkg::CAP_HIGH_ADDR, hi);
        cap_level <= 1'b1;
        idle(3);
        cap_level <= 1'b0;
        rd(timer_pkg::CAP_LOW_ADDR, lo);
        check(lo, v[7:0], "blocked capture");
        rd(timer_pkg::CAP_LOW_ADDR, lo);
        capture_in_stop();
        stop_mode_i <= 1'b0;
        idle(3);
        rd(timer_pkg::CAP_HIGH_ADDR, hi);
        rd(timer_pkg::CAP_LOW_ADDR, lo);
        check(hi, v[15:8], "capture with flag set");
        check(lo, v[7:0], "low read no block");
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h80, "flag held");
        rd(timer_pkg::CAP_LOW_ADDR, lo);
        $display("test_block done");
    endtask

    task automatic test_gpio;
        wr(timer_pkg::CTRL_ADDR, 8'h00);
        port_dout_i <= 2'b10;
        port_ddr_i  <= 2'b10;
        idle(3);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h00, "rising ignored");
        port_dout_i <= 2'b00;
        idle(3);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h80, "gpio falling edge");
        rd(timer_pkg::CAP_LOW_ADDR, lo);
        port_ddr_i <= 2'b00;
        $display("test_gpio done");
    endtask

    task automatic test_compare;
        wr(timer_pkg::CTRL_ADDR, 8'h11);
        rd(timer_pkg::ALT_HIGH_ADDR, hi);
        rd(timer_pkg::ALT_LOW_ADDR, lo);
        v = {hi, lo} + 16'h0010;
        wr(timer_pkg::CMP_HIGH_ADDR, v[15:8]);
        wr(timer_pkg::CMP_LOW_ADDR, v[7:0]);
        check({7'h00, pb_i[0]}, 8'h00, "pin before match");
        idle(80);
        rd(timer_pkg::FLAGS_ADDR, lo);
        check(lo, 8'h40, "compare flag");
        check({7'h00, pb_i[0]}, 8'h01, "pin after match");
        $display("test_compare done");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        idle(6);
        rst_i <= 1'b0;
        test_reset();
        test_overflow();
        test_ctrl();
        test_stop();
        test_block();
        test_gpio();
        test_compare();
        end_of_test();
    end

    // whole run takes well under a thousand cycles
    initial
    begin
        #100000;
        err_count++;
        $display("Error %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
